// >>> cls_pkg.sv
// Constants and types shared by the communication loss supervisor
package cls_pkg;
  // Clock and supervision tick
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_TIME_NS = 100_000_000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int TICK_MS = 100;
  // Channels
  localparam int NCH = 4;
  localparam int CH_FB = 0;
  localparam int CH_SER = 1;
  localparam int CH_KP = 2;
  localparam int CH_PNL = 3;
  // Loss actions
  typedef logic [1:0] cls_act_t;
  localparam cls_act_t ACT_OFF = 2'h0;
  localparam cls_act_t ACT_TRIP = 2'h1;
  localparam cls_act_t ACT_WARN = 2'h2;
  localparam cls_act_t ACT_PNL_WARN = 2'h3;
  // Control source selects
  typedef logic [1:0] cls_src_t;
  localparam cls_src_t SRC_KEYPAD = 2'h0;
  localparam cls_src_t SRC_COM = 2'h1;
  // Delays, in supervision ticks
  typedef logic [7:0] cls_dly_t;
  localparam int DLY_W = 8;
  localparam int DLY_MIN_MS = 100;
  localparam int DLY_MAX_MS = 15000;
  localparam int FB_DLY_DEF_MS = 500;
  localparam int SER_DLY_DEF_MS = 500;
  localparam int KP_DLY_DEF_MS = 2000;
  localparam int PNL_DLY_DEF_MS = 10000;
  localparam cls_dly_t DLY_MIN = cls_dly_t'(DLY_MIN_MS / TICK_MS);
  localparam cls_dly_t DLY_MAX = cls_dly_t'(DLY_MAX_MS / TICK_MS);
  localparam cls_dly_t CNT_MAX = 8'hFF;
  localparam logic [31:0] DLY_RST = {cls_dly_t'(PNL_DLY_DEF_MS / TICK_MS),
    cls_dly_t'(KP_DLY_DEF_MS / TICK_MS), cls_dly_t'(SER_DLY_DEF_MS / TICK_MS),
    cls_dly_t'(FB_DLY_DEF_MS / TICK_MS)};
  // Control register layout
  localparam int CTL_W = 12;
  localparam int CTL_REF_LSB = 8;
  localparam int CTL_RUN_LSB = 10;
  localparam logic [CTL_W-1:0] CTRL_RST = {SRC_KEYPAD, SRC_KEYPAD, ACT_TRIP, ACT_TRIP,
    ACT_OFF, ACT_OFF};
  // Register addresses
  typedef logic [4:0] cls_addr_t;
  localparam cls_addr_t ADDR_CTRL = 5'h00;
  localparam cls_addr_t ADDR_DELAY = 5'h04;
  localparam cls_addr_t ADDR_STATUS = 5'h08;
  localparam cls_addr_t ADDR_MASK = 5'h0C;
  localparam cls_addr_t ADDR_FAULT = 5'h10;
  localparam cls_addr_t ADDR_LIVE = 5'h14;
  // Status and fault bits
  localparam int ST_NET = 4;
  localparam int ST_KPSTOP = 5;
  localparam int ST_W = 6;
  localparam int FLT_TRIP = 0;
  localparam int FLT_WARN = 1;
endpackage

// >>> cls_timer_if.sv
// Link between the supervisor and one channel silence timer
interface cls_timer_if;
  logic arm;
  logic restart;
  logic [7:0] delay;
  logic expired;
  modport ctl (output arm, output restart, output delay, input expired);
  modport tmr (input arm, input restart, input delay, output expired);
endinterface

// >>> cls_tick_gen.sv
// Supervision tick generator
module cls_tick_gen
  import cls_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Tick
  output logic tick_out
);
  logic [31:0] cnt_q;

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      cnt_q <= 32'h0;
      tick_out <= 1'b0;
    end else if (cnt_q == 32'(TICKS - 1)) begin
      cnt_q <= 32'h0;
      tick_out <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick_out <= 1'b0;
    end
  end
endmodule

// >>> cls_chan_timer.sv
// Silence timer of one supervised channel
module cls_chan_timer
  import cls_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Tick
  input wire logic tick_in,
  // Supervisor side
  cls_timer_if.tmr tif
);
  cls_dly_t cnt_q;

  // Saturates so a long silence never wraps back below the delay
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      cnt_q <= 8'h00;
    end else if (!tif.arm || tif.restart) begin // RULE15
      cnt_q <= 8'h00;
    end else if (tick_in && cnt_q != CNT_MAX) begin // RULE16
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign tif.expired = tif.arm && (cnt_q >= tif.delay); // RULE16
endmodule

// >>> cls_comm_loss_supervisor.sv
// Communication loss supervisor for fieldbus, serial, keypad and panel port
// Functional notes
// RULE1: Fieldbus loss action is 0 off, 1 trip, 2 warning, and resets to off.
// RULE2: Armed fieldbus raises its response after silence for the fieldbus delay.
// RULE3: Armed fieldbus also raises its response on any serious network error.
// RULE4: Fieldbus delay runs 0.1 s to 15 s, reset value 0.5 s.
// RULE5: Serial action 1 trips after silence for the serial delay; 0 disables.
// RULE6: Serial action 2 warns instead of tripping after the same silence.
// RULE7: Serial delay runs 0.1 s to 15 s, reset 0.5 s; serial action resets to off.
// RULE8: Fieldbus and serial supervision only act while a source select is comms.
// RULE9: Keypad pulled while running on keypad source stops drive; action 0/1/2, reset 1.
// RULE10: Keypad delay only used for trip or warning; 0.1 s to 15 s, reset 2 s.
// RULE11: Panel port arms only with comms source, command write, run plus direction, action on.
// RULE12: Panel action 0 off, 1 trip, 3 warning, reset trip; response after its delay.
// RULE13: Panel delay runs 0.1 s to 15.0 s, reset 10.0 s.
// RULE14: A panel port master must keep talking faster than the panel delay.
// RULE15: Each silence timer restarts on traffic and is held clear while not armed; the keypad timer restarts on keypad presence instead.
// RULE16: Timers count 0.1 s ticks and compare with delays in the same unit.
//
// The implementer's own choices: strobed register access and the placing of the registers.
module cls_comm_loss_supervisor
  import cls_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Register port
  input wire logic [4:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Channel traffic
  input wire logic fb_rx_valid_in,
  input wire logic fb_net_err_in,
  input wire logic serial_rx_valid_in,
  input wire logic panel_port_rx_valid_in,
  input wire logic panel_port_cmd_wr_in,
  // Drive state
  input wire logic run_cmd_in,
  input wire logic run_right_command_in,
  input wire logic run_left_command_in,
  input wire logic drive_running_in,
  // Keypad presence pin
  input wire logic keypad_present_in,
  // Responses
  output logic trip_out,
  output logic warning_out,
  output logic drive_stop_out,
  output logic irq_out
);
  cls_timer_if tif[NCH] ();

  logic tick;
  logic [CTL_W-1:0] ctrl_q;
  logic [31:0] dly_q;
  logic [ST_W-1:0] stat_q;
  logic [ST_W-1:0] mask_q;
  logic [1:0] flt_q;
  logic kp_meta_q;
  logic kp_sync_q;
  logic pnl_wr_q;
  logic [NCH-1:0] exp_prev_q;
  logic irq_q;
  logic [31:0] rdata_q;
  logic [NCH-1:0] arm_w;
  logic [NCH-1:0] rst_w;
  logic [NCH-1:0] exp_w;
  logic [NCH-1:0] ev_w;
  logic [NCH-1:0] trip_sel;
  logic [NCH-1:0] warn_sel;
  logic [31:0] dly_wr;
  logic [ST_W-1:0] stat_ev;
  cls_act_t act [NCH];
  logic src_com;
  logic src_kp;
  logic net_ev;
  logic kp_stop_d;
  logic trip_set;
  logic warn_set;
  logic wr_stat;
  logic wr_flt;

  cls_tick_gen #(
    .TICKS(TICK_CYCLES_P)
  ) u_tick (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .tick_out(tick)
  );

  // Source selects
  assign src_com = (ctrl_q[CTL_REF_LSB +: 2] == SRC_COM) ||
                   (ctrl_q[CTL_RUN_LSB +: 2] == SRC_COM);
  assign src_kp = (ctrl_q[CTL_REF_LSB +: 2] == SRC_KEYPAD) ||
                  (ctrl_q[CTL_RUN_LSB +: 2] == SRC_KEYPAD);

  // Per channel decode, timer and delay clamp
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [DLY_W-1:0] wf;
    assign act[g] = ctrl_q[2*g +: 2];
    assign trip_sel[g] = (act[g] == ACT_TRIP);
    // Panel port warns on code 3; code 2 there is left unused and means off
    assign warn_sel[g] = (act[g] == ((g == CH_PNL) ? ACT_PNL_WARN : ACT_WARN)); // RULE12
    assign tif[g].arm = arm_w[g];
    assign tif[g].restart = rst_w[g];
    assign tif[g].delay = dly_q[DLY_W*g +: DLY_W]; // RULE16
    assign exp_w[g] = tif[g].expired;
    assign ev_w[g] = exp_w[g] & ~exp_prev_q[g];
    // Out of range delays are clamped, never stored
    assign wf = reg_wdata_in[DLY_W*g +: DLY_W];
    assign dly_wr[DLY_W*g +: DLY_W] = (wf < DLY_MIN) ? DLY_MIN :
                                      (wf > DLY_MAX) ? DLY_MAX : wf; // RULE4
    cls_chan_timer u_tmr (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .tick_in(tick),
      .tif(tif[g])
    );
  end

  // Arming
  assign arm_w[CH_FB] = src_com & (trip_sel[CH_FB] | warn_sel[CH_FB]); // RULE8
  assign arm_w[CH_SER] = src_com & (trip_sel[CH_SER] | warn_sel[CH_SER]); // RULE5
  assign arm_w[CH_KP] = src_kp & drive_running_in & ~kp_sync_q &
                        (trip_sel[CH_KP] | warn_sel[CH_KP]); // RULE10
  assign arm_w[CH_PNL] = src_com & pnl_wr_q & run_cmd_in &
                         (run_right_command_in | run_left_command_in) &
                         (trip_sel[CH_PNL] | warn_sel[CH_PNL]); // RULE11

  // Restart on traffic; the keypad timer restarts while the keypad is seen
  assign rst_w[CH_FB] = fb_rx_valid_in; // RULE15
  assign rst_w[CH_SER] = serial_rx_valid_in;
  assign rst_w[CH_KP] = kp_sync_q;
  assign rst_w[CH_PNL] = panel_port_rx_valid_in; // RULE14

  // Events
  assign net_ev = fb_net_err_in & arm_w[CH_FB]; // RULE3
  assign kp_stop_d = src_kp & drive_running_in & ~kp_sync_q; // RULE9
  assign trip_set = |(ev_w & trip_sel) | (net_ev & trip_sel[CH_FB]); // RULE2
  assign warn_set = |(ev_w & warn_sel) | (net_ev & warn_sel[CH_FB]); // RULE6
  assign stat_ev = {kp_stop_d & ~drive_stop_out, net_ev, ev_w};
  assign wr_stat = reg_wr_in && (reg_addr_in == ADDR_STATUS);
  assign wr_flt = reg_wr_in && (reg_addr_in == ADDR_FAULT);

  // Keypad pin is asynchronous
  // Resets to fitted, so a present keypad never looks pulled right after reset
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      kp_meta_q <= 1'b1;
      kp_sync_q <= 1'b1;
    end else begin
      kp_meta_q <= keypad_present_in;
      kp_sync_q <= kp_meta_q;
    end
  end

  // Control and delay registers
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      ctrl_q <= CTRL_RST; // RULE1
      dly_q <= DLY_RST; // RULE7
    end else if (reg_wr_in && reg_addr_in == ADDR_CTRL) begin
      ctrl_q <= reg_wdata_in[CTL_W-1:0];
    end else if (reg_wr_in && reg_addr_in == ADDR_DELAY) begin
      dly_q <= dly_wr; // RULE13
    end
  end

  // Panel command write latch, dropped when control leaves comms
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pnl_wr_q <= 1'b0;
    end else if (!src_com) begin
      pnl_wr_q <= 1'b0;
    end else if (panel_port_cmd_wr_in) begin
      pnl_wr_q <= 1'b1; // RULE11
    end
  end

  // Edge history and keypad stop
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      exp_prev_q <= '0;
      drive_stop_out <= 1'b0;
    end else begin
      exp_prev_q <= exp_w;
      drive_stop_out <= kp_stop_d; // RULE9
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? reg_wdata_in[ST_W-1:0] : '0)) | stat_ev;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      mask_q <= '0;
    end else if (reg_wr_in && reg_addr_in == ADDR_MASK) begin
      mask_q <= reg_wdata_in[ST_W-1:0];
    end
  end

  // Trip and warning latch until software acknowledges them
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      flt_q <= 2'h0;
    end else begin
      flt_q[FLT_TRIP] <= (flt_q[FLT_TRIP] & ~(wr_flt & reg_wdata_in[FLT_TRIP])) |
                         trip_set; // RULE5
      flt_q[FLT_WARN] <= (flt_q[FLT_WARN] & ~(wr_flt & reg_wdata_in[FLT_WARN])) |
                         warn_set; // RULE6
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // Read data stands for exactly one cycle
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      rdata_q <= 32'h0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_CTRL: rdata_q <= 32'(ctrl_q);
        ADDR_DELAY: rdata_q <= dly_q;
        ADDR_STATUS: rdata_q <= 32'(stat_q);
        ADDR_MASK: rdata_q <= 32'(mask_q);
        ADDR_FAULT: rdata_q <= 32'(flt_q);
        ADDR_LIVE: rdata_q <= 32'({kp_sync_q, pnl_wr_q, arm_w, exp_w});
        default: rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign trip_out = flt_q[FLT_TRIP];
  assign warning_out = flt_q[FLT_WARN];
  assign irq_out = irq_q;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_fb_reset_off;
    $rose(nrst_in) |-> (act[CH_FB] == ACT_OFF) && (act[CH_SER] == ACT_OFF) &&
      (act[CH_KP] == ACT_TRIP) && (act[CH_PNL] == ACT_TRIP);
  endproperty
  a_fb_reset_off: assert property (p_fb_reset_off) // RULE1
    else $error("action reset values wrong");

  property p_fb_trip;
    (ev_w[CH_FB] && trip_sel[CH_FB]) |=> trip_out;
  endproperty
  a_fb_trip: assert property (p_fb_trip) // RULE2
    else $error("fieldbus silence did not trip");

  property p_fb_net_warn;
    (fb_net_err_in && src_com && warn_sel[CH_FB]) |=> warning_out;
  endproperty
  a_fb_net_warn: assert property (p_fb_net_warn) // RULE3
    else $error("fieldbus network error did not warn");

  property p_dly_range;
    (dly_q[DLY_W*CH_FB +: DLY_W] >= DLY_MIN) && (dly_q[DLY_W*CH_FB +: DLY_W] <= DLY_MAX);
  endproperty
  a_dly_range: assert property (p_dly_range) // RULE4
    else $error("fieldbus delay out of range");

  property p_ser_trip;
    (ev_w[CH_SER] && act[CH_SER] == ACT_TRIP) |=> trip_out ##1 trip_out;
  endproperty
  a_ser_trip: assert property (p_ser_trip) // RULE5
    else $error("serial silence did not trip");

  property p_ser_warn;
    (ev_w[CH_SER] && act[CH_SER] == ACT_WARN && !flt_q[FLT_TRIP] && !trip_set)
      |=> warning_out && !trip_out;
  endproperty
  a_ser_warn: assert property (p_ser_warn) // RULE6
    else $error("serial warning wrong");

  property p_src_gate;
    !src_com |-> !arm_w[CH_FB] && !arm_w[CH_SER] && !exp_w[CH_FB] && !exp_w[CH_SER];
  endproperty
  a_src_gate: assert property (p_src_gate) // RULE8
    else $error("supervision active without comms source");

  property p_kp_stop;
    (src_kp && drive_running_in && !kp_sync_q) |=> drive_stop_out;
  endproperty
  a_kp_stop: assert property (p_kp_stop) // RULE9
    else $error("keypad removal did not stop drive");

  property p_pnl_arm;
    arm_w[CH_PNL] |-> src_com && pnl_wr_q && run_cmd_in &&
      (run_right_command_in || run_left_command_in) && (act[CH_PNL] != ACT_WARN);
  endproperty
  a_pnl_arm: assert property (p_pnl_arm) // RULE11
    else $error("panel port armed without conditions");

  property p_restart;
    (arm_w[CH_SER] && rst_w[CH_SER]) |=> !exp_w[CH_SER];
  endproperty
  a_restart: assert property (p_restart) // RULE15
    else $error("serial timer not restarted by traffic");

  property p_stat_set_wins;
    (wr_stat && (stat_ev != '0)) |=> ((stat_q & $past(stat_ev)) == $past(stat_ev));
  endproperty
  a_stat_set_wins: assert property (p_stat_set_wins) // RULE2
    else $error("status event lost against clear");

  property p_fb_net_trip;
    (fb_net_err_in && arm_w[CH_FB] && trip_sel[CH_FB]) |=> trip_out && stat_q[ST_NET];
  endproperty
  a_fb_net_trip: assert property (p_fb_net_trip) // RULE3
    else $error("fieldbus network error did not trip");

  property p_kp_trip;
    (ev_w[CH_KP] && act[CH_KP] == ACT_TRIP) |=> trip_out;
  endproperty
  a_kp_trip: assert property (p_kp_trip) // RULE10
    else $error("keypad silence did not trip");

  property p_kp_no_false_stop;
    kp_sync_q |=> !drive_stop_out;
  endproperty
  a_kp_no_false_stop: assert property (p_kp_no_false_stop) // RULE9
    else $error("drive stopped with keypad fitted");

  property p_pnl_warn;
    (ev_w[CH_PNL] && act[CH_PNL] == ACT_PNL_WARN) |=> warning_out;
  endproperty
  a_pnl_warn: assert property (p_pnl_warn) // RULE12
    else $error("panel port silence did not warn");

  property p_pnl_dly_range;
    (dly_q[DLY_W*CH_PNL +: DLY_W] >= DLY_MIN) && (dly_q[DLY_W*CH_PNL +: DLY_W] <= DLY_MAX);
  endproperty
  a_pnl_dly_range: assert property (p_pnl_dly_range) // RULE13
    else $error("panel port delay out of range");
endmodule

// >>> cls_link_model.sv
// Remote party model that keeps a supervised channel busy
module cls_link_model (
  // Clock
  input wire logic sys_clk_in,
  // Control
  input wire logic talk_in,
  // Traffic
  output logic rx_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] gap_q = 2'h0;
  // Talks every third cycle, so no timer with a delay of two ticks or more can run out
  always_ff @(posedge sys_clk_in) begin
    gap_q <= (gap_q == 2'h2) ? 2'h0 : gap_q + 2'h1;
  end
  assign rx_valid_out = talk_in && (gap_q == 2'h2);
endmodule

// >>> testbench.sv
// Self-checking bench of the communication loss supervisor
module testbench
  import cls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [11:0] ctrl;
    logic talk;
    logic cmdw;
    logic dir;
    logic [1:0] fault;
    logic [3:0] stat;
  } cls_row_t;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic net_err = 1'b0;
  logic talk = 1'b0;
  logic cmd_wr = 1'b0;
  logic run_right = 1'b0;
  logic run_cmd = 1'b1;
  logic run_left = 1'b0;
  logic running = 1'b0;
  logic kp_present = 1'b1;
  logic fb_rx, ser_rx, pnl_rx, trip, warn, stop, irq;
  logic [31:0] rdata;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  cls_row_t rows [13];
  cls_row_t r;

  always #2.5 sys_clk_in = ~sys_clk_in;

  cls_comm_loss_supervisor #(.TICK_CYCLES_P(4)) i_dut (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .fb_rx_valid_in(fb_rx), .fb_net_err_in(net_err),
    .serial_rx_valid_in(ser_rx), .panel_port_rx_valid_in(pnl_rx),
    .panel_port_cmd_wr_in(cmd_wr), .run_cmd_in(run_cmd), .run_right_command_in(run_right),
    .run_left_command_in(run_left), .drive_running_in(running), .keypad_present_in(kp_present),
    .trip_out(trip), .warning_out(warn), .drive_stop_out(stop), .irq_out(irq));
  cls_link_model i_fb_model (.sys_clk_in(sys_clk_in), .talk_in(talk), .rx_valid_out(fb_rx));
  cls_link_model i_ser_model (.sys_clk_in(sys_clk_in), .talk_in(talk), .rx_valid_out(ser_rx));
  cls_link_model i_pnl_model (.sys_clk_in(sys_clk_in), .talk_in(talk), .rx_valid_out(pnl_rx));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // Trailing idle edge keeps a strobe from being lowered and raised in one step
  task automatic wr_reg(input cls_addr_t a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  task automatic rd_chk(input string what, input cls_addr_t a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    @(negedge sys_clk_in);
    check(what, rdata, exp);
    @(posedge sys_clk_in);
  endtask

  task automatic clean();
    talk <= 1'b0;
    wr_reg(ADDR_CTRL, 32'h0);
    wr_reg(ADDR_FAULT, 32'h3);
    wr_reg(ADDR_STATUS, 32'h3F);
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    rows = '{
      '{12'h101, 1'b0, 1'b0, 1'b0, 2'h1, 4'h1},
      '{12'h102, 1'b0, 1'b0, 1'b0, 2'h2, 4'h1},
      '{12'h001, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0},
      '{12'h103, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0},
      '{12'h105, 1'b1, 1'b0, 1'b0, 2'h0, 4'h0},
      '{12'h404, 1'b0, 1'b0, 1'b0, 2'h1, 4'h2},
      '{12'h108, 1'b0, 1'b0, 1'b0, 2'h2, 4'h2},
      '{12'h140, 1'b0, 1'b0, 1'b1, 2'h0, 4'h0},
      '{12'h140, 1'b0, 1'b1, 1'b0, 2'h0, 4'h0},
      '{12'h140, 1'b0, 1'b1, 1'b1, 2'h1, 4'h8},
      '{12'h1C0, 1'b0, 1'b1, 1'b1, 2'h2, 4'h8},
      '{12'h180, 1'b0, 1'b1, 1'b1, 2'h0, 4'h0},
      '{12'h140, 1'b1, 1'b1, 1'b1, 2'h0, 4'h0}};
    cyc(10);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_reg(ADDR_DELAY, 32'h02020202);
    foreach (rows[i]) begin
      r = rows[i];
      run_right <= r.dir;
      talk <= r.talk;
      wr_reg(ADDR_CTRL, {20'h0, r.ctrl});
      cmd_wr <= r.cmdw;
      @(posedge sys_clk_in);
      cmd_wr <= 1'b0;
      cyc(40);
      check("responses", {30'h0, warn, trip}, {30'h0, r.fault});
      rd_chk("fault", ADDR_FAULT, {30'h0, r.fault});
      rd_chk("status", ADDR_STATUS, {28'h0, r.stat});
      clean();
    end
    run_right <= 1'b0;
    // Network error with live traffic, so only the error can trip
    // The error meets a clear of its own status bit, and the error must win
    talk <= 1'b1;
    wr_reg(ADDR_CTRL, 32'h101);
    net_err <= 1'b1;
    addr <= ADDR_STATUS;
    wdata <= 32'h10;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    net_err <= 1'b0;
    wr <= 1'b0;
    cyc(2);
    check("net trip", {31'h0, trip}, 32'h1);
    rd_chk("net status", ADDR_STATUS, 32'h10);
    clean();
    talk <= 1'b1;
    wr_reg(ADDR_CTRL, 32'h102);
    net_err <= 1'b1;
    @(posedge sys_clk_in);
    net_err <= 1'b0;
    cyc(2);
    check("net warn", {30'h0, warn, trip}, 32'h2);
    clean();
    // Run left alone arms the panel port, and the panel port does not arm without run
    run_left <= 1'b1;
    wr_reg(ADDR_CTRL, 32'h140);
    cmd_wr <= 1'b1;
    @(posedge sys_clk_in);
    cmd_wr <= 1'b0;
    cyc(40);
    check("left trip", {31'h0, trip}, 32'h1);
    rd_chk("live", ADDR_LIVE, 32'h388);
    clean();
    run_cmd <= 1'b0;
    wr_reg(ADDR_CTRL, 32'h140);
    cmd_wr <= 1'b1;
    @(posedge sys_clk_in);
    cmd_wr <= 1'b0;
    cyc(40);
    check("no run", {31'h0, trip}, 32'h0);
    run_cmd <= 1'b1;
    run_left <= 1'b0;
    clean();
    // Interrupt follows the mask
    wr_reg(ADDR_MASK, 32'h1);
    wr_reg(ADDR_CTRL, 32'h101);
    cyc(40);
    check("irq set", {31'h0, irq}, 32'h1);
    wr_reg(ADDR_MASK, 32'h0);
    cyc(2);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr_reg(ADDR_MASK, 32'h1);
    clean();
    cyc(2);
    check("irq cleared", {31'h0, irq}, 32'h0);
    // Out of range delays are clamped
    wr_reg(ADDR_DELAY, 32'hFF00FF00);
    rd_chk("clamp", ADDR_DELAY, 32'h96019601);
    wr_reg(ADDR_DELAY, 32'h02020202);
    // Keypad pulled while running on keypad source
    running <= 1'b1;
    wr_reg(ADDR_CTRL, 32'h010);
    cyc(5);
    check("no stop", {31'h0, stop}, 32'h0);
    kp_present <= 1'b0;
    cyc(5);
    check("stop", {31'h0, stop}, 32'h1);
    cyc(40);
    rd_chk("kp fault", ADDR_FAULT, 32'h1);
    rd_chk("kp status", ADDR_STATUS, 32'h24);
    kp_present <= 1'b1;
    running <= 1'b0;
    clean();
    // Second reset: reset values and the default fieldbus delay of five ticks
    nrst_in <= 1'b0;
    cyc(10);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_chk("ctrl rst", ADDR_CTRL, 32'h050);
    rd_chk("delay rst", ADDR_DELAY, 32'h64140505);
    rd_chk("status rst", ADDR_STATUS, 32'h0);
    rd_chk("fault rst", ADDR_FAULT, 32'h0);
    wr_reg(ADDR_CTRL, 32'h101);
    cyc(13);
    check("early", {31'h0, trip}, 32'h0);
    cyc(14);
    check("late", {31'h0, trip}, 32'h1);
    print_verdict();
  end
endmodule
